// ==== rtl/srtc_pkg.sv ====
/*
  shared constants and carrier types of the serial rtc core: register
  offsets, bit positions, power-on values and crystal rates.
  assumes nothing but a systemverilog compiler; nothing is imported.
*/
package srtc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FRACTION = 8'h00;
  localparam logic [7:0] ADDR_SECONDS = 8'h01;
  localparam logic [7:0] ADDR_MINUTES = 8'h02;
  localparam logic [7:0] ADDR_CENTURY_HOURS = 8'h03;
  localparam logic [7:0] ADDR_DAY_OF_WEEK = 8'h04;
  localparam logic [7:0] ADDR_DATE = 8'h05;
  localparam logic [7:0] ADDR_MONTH = 8'h06;
  localparam logic [7:0] ADDR_YEAR = 8'h07;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CLK32K_CTRL = 8'h09;
  localparam logic [7:0] ADDR_ALARM_MONTH = 8'h0a;
  localparam logic [7:0] ADDR_ALARM_DATE = 8'h0b;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0c;
  localparam logic [7:0] ADDR_ALARM_MINUTES = 8'h0d;
  localparam logic [7:0] ADDR_ALARM_SECONDS = 8'h0e;
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h0f;
  localparam logic [7:0] ADDR_RESERVED_A = 8'h10;
  localparam logic [7:0] ADDR_RESERVED_C = 8'h12;
  localparam logic [7:0] ADDR_SQW_RATE = 8'h13;

  // bit positions
  localparam int BIT_OSC_HALT = 7;          // in seconds
  localparam int BIT_CENTURY_TOGGLE_EN = 7; // in century_and_hours
  localparam int BIT_CENTURY_FLAG = 6;      // in century_and_hours
  localparam int BIT_OUT_LEVEL = 7;         // in control
  localparam int BIT_CLK32K_EN = 7;         // in clk32k_output_ctrl
  localparam int BIT_ALARM_IRQ_EN = 7;      // in alarm_month_ctrl
  localparam int BIT_SQW_EN = 6;            // in alarm_month_ctrl
  localparam int BIT_REPEAT_HI = 7;         // repeat 1..4 in 0e..0b
  localparam int BIT_REPEAT5 = 6;           // in alarm_date
  localparam int BIT_ALARM_FLAG = 6;        // in alarm_status
  localparam int SQW_RATE_LSB = 4;          // rate field d7..d4

  // power-on values of the register bytes
  localparam logic [7:0] RST_CONTROL = 8'h80;     // output level high
  localparam logic [7:0] RST_CLK32K_CTRL = 8'h80; // 32 khz output on
  localparam logic [7:0] RST_CLEAR = 8'h00;
  localparam logic [7:0] RST_ONE_BCD = 8'h01;     // day, date, month

  // bcd limits of the counters
  localparam logic [7:0] BCD_MAX_FRACTION = 8'h99;
  localparam logic [7:0] BCD_MAX_SIXTY = 8'h59;
  localparam logic [7:0] BCD_MAX_HOURS = 8'h23;
  localparam logic [7:0] BCD_MAX_DOW = 8'h07;
  localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
  localparam logic [7:0] BCD_MAX_YEAR = 8'h99;

  // crystal and fraction rates
  localparam int XTAL_HZ = 32768;
  localparam int FRACTION_HZ = 100;
  localparam logic [15:0] ACC_STEP = 16'(FRACTION_HZ);
  localparam logic [15:0] ACC_WRAP = 16'(XTAL_HZ);

  // byte events from the serial engine, one-cycle strobes
  typedef struct packed {
    logic ptr_load; // word address byte received
    logic wr;       // data byte received, store at pointer
    logic rd;       // data byte needed for transmission
    logic ack;      // acknowledge clock after a data byte
    logic stop;     // stop condition seen
    logic [7:0] data;
  } srtc_bus_req_t;

endpackage

// ==== rtl/srtc_core.sv ====
/*
  timekeeping core and register file of a serial rtc with alarm,
  square-wave pin and free-running 32 khz pin.
  assumes a serial bit engine on clk_i that delivers byte events as
  one-cycle strobes, and a 32768 hz crystal level on xtal_i from an
  unrelated source; both open-drain pins are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - internal counters copied wholesale into visible copy
// - time write resets the divider chain
// - pointer on time registers freezes visible copy
// - time and alarm BCD, control bytes binary
// - alarm flag cannot be written by host
// - five alarm compare bytes, BCD like time
// - repeat bits select compared alarm fields
// - undefined repeat patterns alarm every second
// - match sets flag, pin low if enabled
// - pointer on flags defers alarm flag
// - flags read clears flag, returns old value
// - rate field selects square-wave frequency
// - 32 khz pin runs unless disabled or halted
// - century flag toggles at rollover when enabled
// - neither enable: pin follows output level bit
// - power-on defaults for halt, enables, level
// - time write zeroes fraction, fraction writes zero
// - halt bit stops all counting
// - pointer increments only on acknowledge clock
module srtc_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xtal_i,
  input wire srtc_pkg::srtc_bus_req_t bus_req_i,
  output logic [7:0] bus_rd_data_o,
  output logic mfp_o,
  output logic mfp_oe_o,
  output logic clk32k_o,
  output logic clk32k_oe_o
);

  // bcd increment: {wrapped, next}; wraps to lo past hi
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
    logic [8:0] r;
    r = 9'h000;
    if (v >= hi) begin
      r = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // last date of a month in bcd, leap years every fourth year
  function automatic logic [7:0] month_len(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    if (mon == 8'h02) begin
      r = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                 mon == 8'h11) begin
      r = 8'h30;
    end else begin
      r = 8'h31;
    end
    return r;
  endfunction

  logic [7:0] tm_reg [0:7];     // internal counting copy
  logic [7:0] tm_next [0:7];    // incremented copy
  logic [7:0] vis_reg [0:7];    // host-visible copy
  logic [7:0] cfg_reg [8:19];   // control, 32k, alarms, rate
  logic [7:0] ptr_reg;          // register pointer
  logic busy_reg;               // inside a transfer
  logic xs1_reg, xs2_reg, xs3_reg; // crystal synchroniser + edge
  logic [15:0] acc_reg;         // fraction phase accumulator
  logic [14:0] div_reg;         // binary divider for square wave
  logic frac_tick_reg;          // one per hundredth of a second
  logic sec_tick_reg;           // new second present in tm_reg
  logic alarm_flag_reg;         // alarm match flag
  logic alarm_pend_reg;         // match held while pointer on flags
  logic [7:0] rd_mux;
  logic wraps;
  logic halt;
  logic xtal_tick;
  logic time_wr;
  logic freeze;
  logic match;
  logic sqw_level;
  logic [4:0] rpt;
  logic [15:0] acc_sum;

  assign halt = tm_reg[1][srtc_pkg::BIT_OSC_HALT];
  assign xtal_tick = xs2_reg & ~xs3_reg;
  assign time_wr = bus_req_i.wr && (ptr_reg <= srtc_pkg::ADDR_YEAR);
  assign freeze = busy_reg && (ptr_reg <= srtc_pkg::ADDR_YEAR);
  assign acc_sum = acc_reg + srtc_pkg::ACC_STEP;

  // two flops before the crystal level is used; third for the edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
    end else begin
      xs1_reg <= xtal_i;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
    end
  end

  // divider chain; fraction rate is 100/32768 on average, exact long term
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg <= 16'h0000;
      div_reg <= 15'h0000;
      frac_tick_reg <= 1'b0;
    end else if (time_wr) begin
      // restart from the newly written time
      acc_reg <= 16'h0000;
      div_reg <= 15'h0000;
      frac_tick_reg <= 1'b0;
    end else if (xtal_tick && !halt) begin
      div_reg <= div_reg + 15'h0001;
      if (acc_sum >= srtc_pkg::ACC_WRAP) begin
        acc_reg <= acc_sum - srtc_pkg::ACC_WRAP;
        frac_tick_reg <= 1'b1;
      end else begin
        acc_reg <= acc_sum;
        frac_tick_reg <= 1'b0;
      end
    end else begin
      // no crystal edge or halted: nothing advances
      frac_tick_reg <= 1'b0;
    end
  end

  // calendar increment, each field masked off its control bits
  always_comb begin
    logic [8:0] r;
    logic c;
    r = 9'h000;
    c = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tm_next[i] = tm_reg[i];
    end
    r = bcd_inc(tm_reg[0], srtc_pkg::BCD_MAX_FRACTION,
                srtc_pkg::RST_CLEAR);
    tm_next[0] = r[7:0];
    c = r[8];
    r = bcd_inc({1'b0, tm_reg[1][6:0]}, srtc_pkg::BCD_MAX_SIXTY,
                srtc_pkg::RST_CLEAR);
    if (c) begin
      tm_next[1] = {tm_reg[1][7], r[6:0]};
    end
    c = c & r[8];
    r = bcd_inc({1'b0, tm_reg[2][6:0]}, srtc_pkg::BCD_MAX_SIXTY,
                srtc_pkg::RST_CLEAR);
    if (c) begin
      tm_next[2] = {1'b0, r[6:0]};
    end
    c = c & r[8];
    r = bcd_inc({2'b00, tm_reg[3][5:0]}, srtc_pkg::BCD_MAX_HOURS,
                srtc_pkg::RST_CLEAR);
    if (c) begin
      tm_next[3] = {tm_reg[3][7:6], r[5:0]};
    end
    c = c & r[8];
    r = bcd_inc(tm_reg[4], srtc_pkg::BCD_MAX_DOW, srtc_pkg::RST_ONE_BCD);
    if (c) begin
      tm_next[4] = r[7:0];
    end
    r = bcd_inc(tm_reg[5], month_len(tm_reg[6], tm_reg[7]),
                srtc_pkg::RST_ONE_BCD);
    if (c) begin
      tm_next[5] = r[7:0];
    end
    c = c & r[8];
    r = bcd_inc(tm_reg[6], srtc_pkg::BCD_MAX_MONTH, srtc_pkg::RST_ONE_BCD);
    if (c) begin
      tm_next[6] = r[7:0];
    end
    c = c & r[8];
    r = bcd_inc(tm_reg[7], srtc_pkg::BCD_MAX_YEAR, srtc_pkg::RST_CLEAR);
    if (c) begin
      tm_next[7] = r[7:0];
    end
    c = c & r[8];
    // century flag flips only with its enable set
    if (c && tm_reg[3][srtc_pkg::BIT_CENTURY_TOGGLE_EN]) begin
      tm_next[3][srtc_pkg::BIT_CENTURY_FLAG] =
        ~tm_reg[3][srtc_pkg::BIT_CENTURY_FLAG];
    end
  end

  // internal time copy: host writes beat the tick in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        tm_reg[i] <= srtc_pkg::RST_CLEAR;
      end
      tm_reg[4] <= srtc_pkg::RST_ONE_BCD;
      tm_reg[5] <= srtc_pkg::RST_ONE_BCD;
      tm_reg[6] <= srtc_pkg::RST_ONE_BCD;
      sec_tick_reg <= 1'b0;
    end else if (time_wr) begin
      // bytes kept as written, bcd is the host's duty
      tm_reg[ptr_reg[2:0]] <= bus_req_i.data;
      tm_reg[0] <= srtc_pkg::RST_CLEAR;
      sec_tick_reg <= 1'b0;
    end else if (frac_tick_reg) begin
      for (int i = 0; i < 8; i++) begin
        tm_reg[i] <= tm_next[i];
      end
      sec_tick_reg <= (tm_reg[0] == srtc_pkg::BCD_MAX_FRACTION);
    end else begin
      sec_tick_reg <= 1'b0;
    end
  end

  // visible copy follows as one block unless frozen by the pointer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        vis_reg[i] <= srtc_pkg::RST_CLEAR;
      end
    end else if (!freeze) begin
      for (int i = 0; i < 8; i++) begin
        vis_reg[i] <= tm_reg[i];
      end
    end
  end

  // transfer state: a stop ends the freeze window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (bus_req_i.stop) begin
      busy_reg <= 1'b0;
    end else if (bus_req_i.ptr_load || bus_req_i.wr || bus_req_i.rd) begin
      busy_reg <= 1'b1;
    end
  end

  // pointer: loaded by address byte, stepped on acknowledge clock only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= srtc_pkg::ADDR_FRACTION;
    end else if (bus_req_i.ptr_load) begin
      ptr_reg <= bus_req_i.data;
    end else if (bus_req_i.ack) begin
      // past the last register the pointer wraps to the first
      if (ptr_reg >= srtc_pkg::ADDR_SQW_RATE) begin
        ptr_reg <= srtc_pkg::ADDR_FRACTION;
      end else begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  // control and alarm bytes; flags and reserved bytes take no write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 8; i < 20; i++) begin
        cfg_reg[i] <= srtc_pkg::RST_CLEAR;
      end
      cfg_reg[8] <= srtc_pkg::RST_CONTROL;
      cfg_reg[9] <= srtc_pkg::RST_CLK32K_CTRL;
    end else if (bus_req_i.wr && ptr_reg >= srtc_pkg::ADDR_CONTROL &&
                 ptr_reg <= srtc_pkg::ADDR_SQW_RATE &&
                 ptr_reg != srtc_pkg::ADDR_ALARM_STATUS &&
                 (ptr_reg < srtc_pkg::ADDR_RESERVED_A ||
                  ptr_reg > srtc_pkg::ADDR_RESERVED_C)) begin
      cfg_reg[5'(ptr_reg)] <= bus_req_i.data;
    end
  end

  // repeat bits, repeat5 first
  assign rpt = {cfg_reg[11][srtc_pkg::BIT_REPEAT5],
                cfg_reg[11][srtc_pkg::BIT_REPEAT_HI],
                cfg_reg[12][srtc_pkg::BIT_REPEAT_HI],
                cfg_reg[13][srtc_pkg::BIT_REPEAT_HI],
                cfg_reg[14][srtc_pkg::BIT_REPEAT_HI]};

  // field compare under the repeat pattern
  always_comb begin
    logic s_eq, m_eq, h_eq, d_eq, mo_eq;
    s_eq = tm_reg[1][6:0] == cfg_reg[14][6:0];
    m_eq = tm_reg[2][6:0] == cfg_reg[13][6:0];
    h_eq = tm_reg[3][5:0] == cfg_reg[12][5:0];
    d_eq = tm_reg[5][5:0] == cfg_reg[11][5:0];
    mo_eq = tm_reg[6][4:0] == cfg_reg[10][4:0];
    case (rpt)
      5'b11110: match = s_eq;
      5'b11100: match = s_eq & m_eq;
      5'b11000: match = s_eq & m_eq & h_eq;
      5'b10000: match = s_eq & m_eq & h_eq & d_eq;
      5'b00000: match = s_eq & m_eq & h_eq & d_eq & mo_eq;
      // all ones and every stray pattern: each second
      default: match = 1'b1;
    endcase
  end

  // alarm flag: read clears only with pointer on flags; a set is parked while on flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_flag_reg <= 1'b0;
      alarm_pend_reg <= 1'b0;
    end else begin
      if (ptr_reg == srtc_pkg::ADDR_ALARM_STATUS) begin
        if (sec_tick_reg && match) begin
          alarm_pend_reg <= 1'b1;
        end
        if (bus_req_i.rd) begin
          alarm_flag_reg <= 1'b0;
        end
      end else begin
        alarm_pend_reg <= 1'b0;
        if ((sec_tick_reg && match) || alarm_pend_reg) begin
          alarm_flag_reg <= 1'b1;
        end
      end
    end
  end

  // register read mux; the flag bit is the only live bit at 0f
  always_comb begin
    rd_mux = 8'h00;
    if (ptr_reg <= srtc_pkg::ADDR_YEAR) begin
      rd_mux = vis_reg[ptr_reg[2:0]];
    end else if (ptr_reg == srtc_pkg::ADDR_ALARM_STATUS) begin
      rd_mux[srtc_pkg::BIT_ALARM_FLAG] = alarm_flag_reg;
    end else if (ptr_reg >= srtc_pkg::ADDR_RESERVED_A &&
                 ptr_reg <= srtc_pkg::ADDR_RESERVED_C) begin
      rd_mux = 8'h00;
    end else if (ptr_reg <= srtc_pkg::ADDR_SQW_RATE) begin
      rd_mux = cfg_reg[5'(ptr_reg)];
    end
  end

  // read data captured before the clear lands, so old flag is seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rd_data_o <= 8'h00;
    end else if (bus_req_i.rd) begin
      bus_rd_data_o <= rd_mux;
    end
  end

  // rate code 1 is the crystal itself, code n>1 taps divider bit n-1
  always_comb begin
    logic [3:0] code;
    code = cfg_reg[19][srtc_pkg::SQW_RATE_LSB +: 4];
    if (halt || code == 4'h0) begin
      sqw_level = 1'b1;
    end else if (code == 4'h1) begin
      sqw_level = xs3_reg;
    end else begin
      sqw_level = div_reg[code - 4'h1];
    end
  end

  // open-drain pins: enable high pulls the pin low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mfp_o <= 1'b0;
      mfp_oe_o <= 1'b0;
      clk32k_o <= 1'b0;
      clk32k_oe_o <= 1'b0;
    end else begin
      mfp_o <= 1'b0;
      clk32k_o <= 1'b0;
      if (cfg_reg[10][srtc_pkg::BIT_SQW_EN]) begin
        mfp_oe_o <= ~sqw_level;
      end else if (cfg_reg[10][srtc_pkg::BIT_ALARM_IRQ_EN]) begin
        mfp_oe_o <= alarm_flag_reg;
      end else begin
        mfp_oe_o <= ~cfg_reg[8][srtc_pkg::BIT_OUT_LEVEL];
      end
      clk32k_oe_o <= cfg_reg[9][srtc_pkg::BIT_CLK32K_EN] && !halt &&
                     !xs3_reg;
    end
  end

endmodule

`default_nettype wire

// ==== sim/srtc_core_properties.sv ====
/*
  checker for srtc_core, bound to its ports after the module.
  assumes the shadows below follow the byte events as the core does.
*/
`timescale 1ns/1ps
`default_nettype none
module srtc_core_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xtal_i,
  input wire srtc_pkg::srtc_bus_req_t bus_req_i,
  input wire logic [7:0] bus_rd_data_o,
  input wire logic mfp_o,
  input wire logic mfp_oe_o,
  input wire logic clk32k_o,
  input wire logic clk32k_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [7:0] ptr_reg; // pointer shadow
  logic out_reg; // control output level
  logic k32_reg; // 32 khz enable
  logic halt_reg; // oscillator halt
  logic [1:0] ena_reg; // irq enable, square enable
  logic [3:0] rate_reg; // square-wave rate code

  // pointer shadow: a load wins over an acknowledge clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= 8'h00;
    end else if (bus_req_i.ptr_load) begin
      ptr_reg <= bus_req_i.data;
    end else if (bus_req_i.ack) begin
      ptr_reg <= (ptr_reg >= 8'h13) ? 8'h00 : ptr_reg + 8'h01;
    end
  end

  // control shadows; a write uses the pointer before any load
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {out_reg, k32_reg, halt_reg, ena_reg, rate_reg} <= 9'h180;
    end else if (bus_req_i.wr) begin
      case (ptr_reg)
        8'h01: halt_reg <= bus_req_i.data[7];
        8'h08: out_reg <= bus_req_i.data[7];
        8'h09: k32_reg <= bus_req_i.data[7];
        8'h0a: ena_reg <= bus_req_i.data[7:6];
        8'h13: rate_reg <= bus_req_i.data[7:4];
        default: ;
      endcase
    end
  end

  chk_mfp_data_low: assert property (mfp_o == 1'b0)
    else $error("mfp data not low");
  chk_k32_data_low: assert property (clk32k_o == 1'b0)
    else $error("32k data not low");
  chk_rd_data_holds: assert property (!bus_req_i.rd
    |=> $stable(bus_rd_data_o)) else $error("read byte moved");
  chk_rsvd_reads_zero: assert property (bus_req_i.rd
    && ptr_reg inside {[8'h10:8'h12]} |=> bus_rd_data_o == 8'h00)
    else $error("reserved read not zero");
  chk_flag_only_bit: assert property (bus_req_i.rd
    && ptr_reg == 8'h0f |=> (bus_rd_data_o & 8'hbf) == 8'h00)
    else $error("flags byte has stray bits");
  chk_out_level_pin: assert property (
    (ena_reg == 2'b00 && $stable(out_reg)) [*3] |-> mfp_oe_o == !out_reg)
    else $error("pin does not follow level bit");
  chk_sqw_released: assert property (
    (ena_reg[0] && (rate_reg == 4'h0 || halt_reg)) [*4] |-> !mfp_oe_o)
    else $error("square wave not released");
  chk_k32_stopped: assert property (
    (!k32_reg || halt_reg) [*4] |-> !clk32k_oe_o)
    else $error("32k pin still driven");
  chk_flag_read_release: assert property (bus_req_i.rd
    && ptr_reg == 8'h0f && ena_reg == 2'b10 |-> ##2 !mfp_oe_o)
    else $error("irq kept after flags read");
  chk_parked_no_irq: assert property (
    (ena_reg == 2'b10 && ptr_reg == 8'h0f) [*4] |-> !$rose(mfp_oe_o))
    else $error("irq raised with pointer on flags");
endmodule

bind srtc_core srtc_core_properties chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal_i), .bus_req_i(bus_req_i),
  .bus_rd_data_o(bus_rd_data_o), .mfp_o(mfp_o), .mfp_oe_o(mfp_oe_o),
  .clk32k_o(clk32k_o), .clk32k_oe_o(clk32k_oe_o)
);
`default_nettype wire

// ==== sim/srtc_host_model.sv ====
/*
  host stand-in: byte events of a bus master and a crystal source.
  assumes strobes of one cycle, launched on falling clk_i edges.
*/
`timescale 1ns/1ps
`default_nettype none
module srtc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  output var srtc_pkg::srtc_bus_req_t req_o,
  output var logic xtal_o
);
  // quiet bus at time zero
  initial begin
    req_o = '0;
    xtal_o = 1'b0;
  end

  // crystal sped up to three clk_i cycles so a second fits the run;
  // edges sit 5 ns off every clk_i edge so the sampling never races
  initial begin
    #5;
    forever #37.5 xtal_o = ~xtal_o;
  end

  // one strobe for one cycle; kind is ptr_load, wr, rd, ack, stop
  task automatic pulse(input logic [4:0] kind, input logic [7:0] d);
    @(negedge clk_i);
    req_o = {kind, d};
    @(negedge clk_i);
    req_o = '0;
  endtask

  // pointer, acked data bytes, stop; fixed-zero bits left zero
  task automatic write_seq(input logic [7:0] a, input logic [7:0] q[$]);
    pulse(5'h10, a);
    foreach (q[i]) begin
      pulse(5'h08, q[i]);
      pulse(5'h02, 8'h00);
    end
    pulse(5'h01, 8'h00);
  endtask

  // last byte of a read is not acked, as a master receiver does
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    pulse(5'h10, a);
    pulse(5'h04, 8'h00);
    @(negedge clk_i);
    d = rd_data_i;
    pulse(5'h01, 8'h00);
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_serial_rtc_alarm_sqw_core.sv ====
/*
  self-checking bench for srtc_core driven by the host model.
  assumes the host crystal period is three clk_i cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_serial_rtc_alarm_sqw_core;
  logic clk_i = 1'b0; // 40 mhz
  logic rst_i = 1'b1; // held 20 cycles
  srtc_pkg::srtc_bus_req_t bus_req; // host byte events
  logic xtal; // crystal stand-in
  logic [7:0] rd_data; // read byte
  logic mfp, mfp_oe, k32, k32_oe; // pin outputs
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] got; // scratch read
  int n; // scratch toggle count

  always #12.5 clk_i = ~clk_i;

  srtc_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal),
    .bus_req_i(bus_req), .bus_rd_data_o(rd_data), .mfp_o(mfp),
    .mfp_oe_o(mfp_oe), .clk32k_o(k32), .clk32k_oe_o(k32_oe));
  srtc_host_model host_u (.clk_i(clk_i), .rd_data_i(rd_data),
    .req_o(bus_req), .xtal_o(xtal));

  // counts, verdict, end of run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // counts of edges carry phase slack, hence a tolerance
  task automatic check_near(input int g, input int e, input int t);
    cmp_count++;
    if (g < e - t || g > e + t) begin
      bad_count++;
      $display("Error at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_u.read_reg(a, got);
    check8(got, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_seq(a, {d});
  endtask

  // level changes of one pin over 240 cycles after settling
  task automatic toggles(input logic pick, output int c);
    logic last;
    c = 0;
    repeat (8) @(negedge clk_i);
    last = pick ? k32_oe : mfp_oe;
    repeat (240) begin
      @(negedge clk_i);
      if ((pick ? k32_oe : mfp_oe) !== last) c++;
      last = pick ? k32_oe : mfp_oe;
    end
  endtask

  task automatic t_defaults();
    rd_chk(8'h08, 8'h80);
    rd_chk(8'h09, 8'h80);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h01, 8'h00);
    check8({7'h0, mfp_oe}, 8'h00);
  endtask

  task automatic t_out_level();
    wr(8'h08, 8'h00);
    check8({7'h0, mfp_oe}, 8'h01);
    wr(8'h08, 8'h80);
    check8({7'h0, mfp_oe}, 8'h00);
  endtask

  // bytes that must not be kept, then a pointer run
  task automatic t_refused();
    wr(8'h00, 8'h55);
    rd_chk(8'h00, 8'h00);
    wr(8'h0f, 8'h40);
    rd_chk(8'h0f, 8'h00);
    rd_chk(8'h11, 8'h00);
    host_u.write_seq(8'h0c, {8'h15, 8'h27, 8'h38});
    rd_chk(8'h0d, 8'h27);
    rd_chk(8'h0e, 8'h38);
  endtask

  // pointer left on fraction: visible copy held until the stop
  task automatic t_freeze();
    wr(8'h00, 8'h00);
    host_u.pulse(5'h10, 8'h00);
    // one fraction tick falls about 984 cycles after the write
    repeat (1100) @(negedge clk_i);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h00, 8'h01);
  endtask

  // undefined repeat pattern fires each second; parked on flags it waits
  task automatic t_alarm();
    host_u.write_seq(8'h0a, {8'h80, 8'h00, 8'h00, 8'h00, 8'h80});
    wr(8'h01, 8'h00);
    // the tick lands about 98304 cycles after the write restarts the chain
    repeat (32768 * 3 - 40) @(negedge clk_i);
    check8({7'h0, mfp_oe}, 8'h00);
    host_u.pulse(5'h10, 8'h0f);
    repeat (80) @(negedge clk_i);
    check8({7'h0, mfp_oe}, 8'h00);
    rd_chk(8'h01, 8'h01);
    check8({7'h0, mfp_oe}, 8'h01);
    rd_chk(8'h0f, 8'h40);
    check8({7'h0, mfp_oe}, 8'h00);
    rd_chk(8'h0f, 8'h00);
  endtask

  // 80 crystal periods per window: code 1 gives 160 changes, code 2 gives 40, then halves
  task automatic t_sqw();
    int exp_n [4] = '{0, 160, 40, 20};
    wr(8'h0a, 8'hc0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h13, {4'(k), 4'h0});
      toggles(1'b0, n);
      check_near(n, exp_n[k], 3);
    end
    wr(8'h0a, 8'h00);
  endtask

  task automatic t_k32();
    toggles(1'b1, n);
    check_near(n, 160, 3);
    wr(8'h09, 8'h00);
    toggles(1'b1, n);
    check_near(n, 0, 0);
    wr(8'h09, 8'h80);
    wr(8'h01, 8'h80);
    toggles(1'b1, n);
    check_near(n, 0, 0);
    wr(8'h01, 8'h00);
    toggles(1'b1, n);
    check_near(n, 160, 3);
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_defaults();
    t_out_level();
    t_refused();
    t_freeze();
    t_alarm();
    t_sqw();
    t_k32();
    end_of_test();
  end
endmodule
`default_nettype wire
